// file: core/correlator_control_readout.sv
// Overview of operation
// RULE_01 - chain position is none, first, intermediate, last
// RULE_02 - none position disables every chaining bus
// RULE_03 - first: local input, export on chaining buses
// RULE_04 - intermediate: import one bus, export other
// RULE_05 - last: import buses, export nothing
// RULE_06 - links carry delayed and undelayed samples
// RULE_07 - single sync master, clock derived from sync
// RULE_08 - half select picks lower or upper eight lines
// RULE_09 - routing registers hold 3-bit event line numbers
// RULE_10 - host routes optional fields to unused lines
// RULE_11 - register 0xc selects sources and divider
// RULE_12 - chip enable registers, zero means normal run
// RULE_13 - run high, blank low, integrate accumulates
// RULE_14 - integrate fall publishes results, clears accumulators
// RULE_15 - blank holds accumulators, samples keep shifting
// RULE_16 - run low stops shifting, accumulation continues
// RULE_17 - results read once, lag order, 1025 words
// RULE_18 - host reads before next integration ends
// RULE_19 - enable bit 0x0020 allows result retrieval
// RULE_20 - chip select bit picks the IC read
// RULE_21 - host reads low half then high half
// RULE_22 - high half read advances to next word
// RULE_23 - event bus has sixteen lines plus strobe
// RULE_24 - low read latches the matching high half
// RULE_25 - control registers read back last write
`timescale 1ns/10ps

module result_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : result_fifo

module correlator_control_readout (
  input wire logic ref_clk,
  input wire logic rst,
  input wire corr_pkg::bcp_req_t bcp_req,
  output logic bcp_ack,
  output logic [15:0] bcp_rdata,
  input wire logic [15:0] event_lines,
  input wire logic event_bus_strobe,
  output corr_pkg::ic_ctrl_t ic_ctrl [2],
  input wire corr_pkg::chain_link_t sampler_sample [2],
  input wire corr_pkg::chain_link_t aux_sample,
  output corr_pkg::chain_link_t ic_sample [2],
  input wire corr_pkg::chain_link_t link_left_in,
  input wire corr_pkg::chain_link_t link_right_in,
  output corr_pkg::chain_link_t link_left_out,
  output logic link_left_oe,
  output corr_pkg::chain_link_t link_right_out,
  output logic link_right_oe,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic corr_clk_tick,
  input wire logic [1:0] result_valid,
  output logic [1:0] result_ready,
  input wire logic [31:0] result_data [2]
);
  import corr_pkg::*;

  logic [15:0] event_routing [2];
  logic [15:0] chip_enable [2];
  logic [15:0] event_range_control;
  logic [15:0] readout_control;
  logic [15:0] datapath_clock_select;
  logic [15:0] high_hold;
  readout_state_t rd_state;

  logic [15:0] event_meta;
  logic [15:0] event_sync;
  logic [2:0] strobe_sync;
  logic [15:0] event_level;
  logic [2:0] sync_pin;
  chain_link_t sampler_meta [2];
  chain_link_t sampler_sync [2];
  chain_link_t aux_meta;
  chain_link_t aux_sync;
  chain_link_t left_meta;
  chain_link_t left_sync;
  chain_link_t right_meta;
  chain_link_t right_sync;

  chain_pos_t chain_pos;
  logic sync_master;
  logic [7:0] event_half;
  logic [1:0] integ_prev;
  logic [1:0] integ_fall;
  logic [2:0] divider;
  logic [7:0] div_count;
  logic [10:0] words_left;
  logic chip_sel;
  logic readout_enable;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [31:0] fifo_out_data;
  logic rd_low;
  logic rd_high;

  assign chain_pos = chain_pos_t'(event_range_control[POS_CHAIN_POS +: 2]); // RULE_01
  assign sync_master = event_range_control[POS_SYNC_MASTER];
  assign divider = datapath_clock_select[POS_DIVIDER +: 3]; // RULE_11
  assign chip_sel = readout_control[POS_CHIP_SELECT]; // RULE_20
  assign readout_enable = readout_control[POS_HOST_READOUT_ENABLE]; // RULE_19
  assign rd_low = bcp_req.rd && (bcp_req.addr == OFS_RESULT_LOW_HALF);
  assign rd_high = bcp_req.rd && (bcp_req.addr == OFS_RESULT_HIGH_HALF);

  // every pin-side input passes two flops before use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      event_meta <= '0;
      event_sync <= '0;
      strobe_sync <= '0;
      sync_pin <= '0;
    end else begin
      event_meta <= event_lines;
      event_sync <= event_meta;
      strobe_sync <= {strobe_sync[1:0], event_bus_strobe};
      sync_pin <= {sync_pin[1:0], sync_in};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sampler_meta <= '{default: '0};
      sampler_sync <= '{default: '0};
      aux_meta <= '0;
      aux_sync <= '0;
      left_meta <= '0;
      left_sync <= '0;
      right_meta <= '0;
      right_sync <= '0;
    end else begin
      sampler_meta <= sampler_sample;
      sampler_sync <= sampler_meta;
      aux_meta <= aux_sample;
      aux_sync <= aux_meta;
      left_meta <= link_left_in;
      left_sync <= left_meta;
      right_meta <= link_right_in;
      right_sync <= right_meta;
    end
  end

  // lines are taken on the strobe's rising edge; they are assumed settled by then
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      event_level <= '0;
    end else if (strobe_sync[1] && !strobe_sync[2]) begin
      event_level <= event_sync; // RULE_23
    end
  end

  assign event_half = event_range_control[POS_EVENT_HALF_SELECT] ?
                      event_level[15:8] : event_level[7:0]; // RULE_08

  // control registers, all read back as written
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      event_routing <= '{default: REG_RESET};
      chip_enable <= '{default: REG_RESET}; // RULE_12
      event_range_control <= REG_RESET;
      readout_control <= REG_RESET;
      datapath_clock_select <= REG_RESET;
    end else if (bcp_req.wr) begin
      case (bcp_req.addr)
        OFS_EVENT_ROUTING_IC0: event_routing[0] <= bcp_req.wdata;
        OFS_EVENT_ROUTING_IC1: event_routing[1] <= bcp_req.wdata;
        OFS_CHIP_ENABLE_IC0: chip_enable[0] <= bcp_req.wdata;
        OFS_CHIP_ENABLE_IC1: chip_enable[1] <= bcp_req.wdata;
        OFS_EVENT_RANGE_CONTROL: event_range_control <= bcp_req.wdata;
        OFS_READOUT_CONTROL: readout_control <= bcp_req.wdata;
        OFS_DATAPATH_CLOCK_SELECT: datapath_clock_select <= bcp_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bcp_ack <= 1'b0;
      bcp_rdata <= '0;
    end else begin
      bcp_ack <= bcp_req.rd || bcp_req.wr;
      if (bcp_req.rd) begin
        case (bcp_req.addr)
          OFS_EVENT_ROUTING_IC0: bcp_rdata <= event_routing[0]; // RULE_25
          OFS_EVENT_ROUTING_IC1: bcp_rdata <= event_routing[1]; // RULE_25
          OFS_CHIP_ENABLE_IC0: bcp_rdata <= chip_enable[0];
          OFS_CHIP_ENABLE_IC1: bcp_rdata <= chip_enable[1];
          OFS_EVENT_RANGE_CONTROL: bcp_rdata <= event_range_control;
          OFS_READOUT_CONTROL: bcp_rdata <= readout_control;
          OFS_DATAPATH_CLOCK_SELECT: bcp_rdata <= datapath_clock_select;
          OFS_RESULT_LOW_HALF: bcp_rdata <= fifo_out_valid ? fifo_out_data[15:0] : '0; // RULE_21
          OFS_RESULT_HIGH_HALF: bcp_rdata <= high_hold;
          default: bcp_rdata <= '0;
        endcase
      end
    end
  end

  // per-IC dynamic control from routed event lines
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ic
      logic blank;
      logic integ;
      logic run;
      source_t src;
      chain_link_t picked;

      assign blank = event_half[event_routing[gi][POS_BLANK +: 3]]; // RULE_09
      assign integ = event_half[event_routing[gi][POS_INTEGRATE +: 3]];
      assign run = event_half[event_routing[gi][POS_RUN +: 3]];
      assign integ_fall[gi] = integ_prev[gi] && !integ;
      assign src = source_t'(datapath_clock_select[(gi == 0 ? POS_SRC_IC0 : POS_SRC_IC1) +: 2]);

      always_comb begin
        picked = sampler_sync[gi];
        case (src)
          SRC_SAMPLER: picked = sampler_sync[gi]; // RULE_03
          SRC_AUX: picked = aux_sync; // RULE_03
          SRC_LEFT: picked = (chain_pos inside {CHAIN_INTERMEDIATE, CHAIN_LAST}) ?
                             left_sync : sampler_sync[gi]; // RULE_05
          SRC_RIGHT: picked = (chain_pos inside {CHAIN_INTERMEDIATE, CHAIN_LAST}) ?
                              right_sync : sampler_sync[gi]; // RULE_05
          default: picked = sampler_sync[gi];
        endcase
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          integ_prev[gi] <= 1'b0;
          ic_ctrl[gi] <= '0;
          ic_sample[gi] <= '0;
        end else begin
          integ_prev[gi] <= integ;
          ic_sample[gi] <= picked;
          ic_ctrl[gi].shift_en <= run; // RULE_15 RULE_16
          ic_ctrl[gi].acc_en <= integ && !blank; // RULE_13 RULE_15 RULE_16
          ic_ctrl[gi].acc_clear <= integ_prev[gi] && !integ; // RULE_14
          ic_ctrl[gi].sampler_sync <= event_half[event_routing[gi][POS_SAMPLER_SYNC +: 3]];
          ic_ctrl[gi].sampler_blank <= event_half[event_routing[gi][POS_SAMPLER_BLANK +: 3]];
          ic_ctrl[gi].input_mode <= chip_enable[gi][POS_INPUT_MODE]; // RULE_12
          ic_ctrl[gi].test <= chip_enable[gi][POS_TEST];
          ic_ctrl[gi].dbl <= chip_enable[gi][POS_DOUBLE];
          ic_ctrl[gi].chip_reset <= chip_enable[gi][POS_CHIP_RESET];
        end
      end
    end
  endgenerate

  // chaining bus export; both streams travel together on every link
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link_left_out <= '0;
      link_right_out <= '0;
      link_left_oe <= 1'b0;
      link_right_oe <= 1'b0;
    end else begin
      case (chain_pos)
        CHAIN_FIRST: begin
          link_left_out <= ic_sample[0]; // RULE_03 RULE_06
          link_right_out <= ic_sample[1]; // RULE_06
          link_left_oe <= 1'b1;
          link_right_oe <= 1'b1;
        end
        CHAIN_INTERMEDIATE: begin
          // import from one side, pass onward through the other
          link_left_out <= event_range_control[POS_EXPORT_RIGHT] ? '0 : right_sync; // RULE_04
          link_right_out <= event_range_control[POS_EXPORT_RIGHT] ? left_sync : '0; // RULE_04
          link_left_oe <= !event_range_control[POS_EXPORT_RIGHT];
          link_right_oe <= event_range_control[POS_EXPORT_RIGHT];
        end
        default: begin
          link_left_out <= '0; // RULE_02 RULE_05
          link_right_out <= '0;
          link_left_oe <= 1'b0;
          link_right_oe <= 1'b0;
        end
      endcase
    end
  end

  // correlator clock divider, realigned on the shared sync edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_count <= '0;
      corr_clk_tick <= 1'b0;
      sync_out <= 1'b0;
      sync_oe <= 1'b0;
    end else begin
      sync_oe <= sync_master; // RULE_07
      if (sync_pin[1] && !sync_pin[2]) begin
        div_count <= '0; // RULE_07
      end else begin
        div_count <= div_count + 1'b1;
      end
      // divider 0 ticks every cycle: full correlator rate
      corr_clk_tick <= ((div_count & ((8'h01 << divider) - 8'h01)) == 8'h00); // RULE_11
      // the master exports its slowest count bit, which all modules follow
      sync_out <= sync_master && div_count[7]; // RULE_07
    end
  end

  // result capture from the selected IC, at most one frame per integration
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      words_left <= '0;
    end else if (integ_fall[chip_sel]) begin
      words_left <= RESULT_READS; // RULE_17 RULE_14
    end else if (fifo_in_valid && fifo_in_ready) begin
      words_left <= words_left - 11'd1;
    end
  end

  assign fifo_in_valid = readout_enable && result_valid[chip_sel] && (words_left != '0);
  assign result_ready[0] = !chip_sel && readout_enable && fifo_in_ready && (words_left != '0);
  assign result_ready[1] = chip_sel && readout_enable && fifo_in_ready && (words_left != '0);
  assign fifo_pop = rd_high && (rd_state == RD_WAIT_HIGH) && fifo_out_valid; // RULE_22

  // a new frame overwrites what the host has not yet read
  result_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .flush(integ_fall[chip_sel]),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(result_data[chip_sel]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_state <= RD_WAIT_LOW;
      high_hold <= '0;
    end else begin
      case (rd_state)
        RD_WAIT_LOW: begin
          if (rd_low && fifo_out_valid) begin
            high_hold <= fifo_out_data[31:16]; // RULE_24
            rd_state <= RD_WAIT_HIGH;
          end
        end
        RD_WAIT_HIGH: begin
          if (rd_high) begin
            rd_state <= RD_WAIT_LOW; // RULE_22
          end else if (rd_low && fifo_out_valid) begin
            high_hold <= fifo_out_data[31:16];
          end
        end
        default: rd_state <= RD_WAIT_LOW;
      endcase
    end
  end
endmodule : correlator_control_readout

// file: pkg/corr_pkg.sv
package corr_pkg;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned RESULT_W = 32;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned EVENT_LINES = 16;

  // register offsets on the block control port
  localparam logic [14:0] OFS_EVENT_ROUTING_IC0 = 15'h0000;
  localparam logic [14:0] OFS_EVENT_ROUTING_IC1 = 15'h0001;
  localparam logic [14:0] OFS_CHIP_ENABLE_IC0 = 15'h0002;
  localparam logic [14:0] OFS_CHIP_ENABLE_IC1 = 15'h0003;
  localparam logic [14:0] OFS_EVENT_RANGE_CONTROL = 15'h0004;
  localparam logic [14:0] OFS_RESULT_LOW_HALF = 15'h0008;
  localparam logic [14:0] OFS_RESULT_HIGH_HALF = 15'h0009;
  localparam logic [14:0] OFS_READOUT_CONTROL = 15'h000a;
  localparam logic [14:0] OFS_DATAPATH_CLOCK_SELECT = 15'h000c;

  localparam logic [15:0] REG_RESET = 16'h0000;

  // event routing fields, 3 bits each
  localparam int unsigned POS_BLANK = 12;
  localparam int unsigned POS_INTEGRATE = 9;
  localparam int unsigned POS_RUN = 6;
  localparam int unsigned POS_SAMPLER_SYNC = 3;
  localparam int unsigned POS_SAMPLER_BLANK = 0;

  // chip enable fields
  localparam int unsigned POS_INPUT_MODE = 0;
  localparam int unsigned POS_TEST = 1;
  localparam int unsigned POS_DOUBLE = 2;
  localparam int unsigned POS_CHIP_RESET = 3;

  // event range control fields
  localparam int unsigned POS_CHAIN_POS = 0;
  localparam int unsigned POS_SYNC_MASTER = 2;
  localparam int unsigned POS_EXPORT_RIGHT = 3;
  localparam int unsigned POS_EVENT_HALF_SELECT = 8;

  // readout control fields
  localparam int unsigned POS_CHIP_SELECT = 0;
  localparam int unsigned POS_HOST_READOUT_ENABLE = 5;

  // datapath clock select fields, 2 bits per source
  localparam int unsigned POS_SRC_IC0 = 4;
  localparam int unsigned POS_SRC_IC1 = 6;
  localparam int unsigned POS_DIVIDER = 8;

  localparam logic [10:0] RESULT_READS = 11'd1025;

  typedef enum logic [1:0] {
    CHAIN_NONE = 2'h0, CHAIN_FIRST = 2'h1, CHAIN_INTERMEDIATE = 2'h2, CHAIN_LAST = 2'h3
  } chain_pos_t;

  typedef enum logic [1:0] {
    SRC_SAMPLER = 2'h0, SRC_AUX = 2'h1, SRC_LEFT = 2'h2, SRC_RIGHT = 2'h3
  } source_t;

  typedef enum logic [1:0] {RD_WAIT_LOW = 2'b01, RD_WAIT_HIGH = 2'b10} readout_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [14:0] addr;
    logic [15:0] wdata;
  } bcp_req_t;

  typedef struct packed {
    logic [1:0] delayed;
    logic [1:0] undelayed;
  } chain_link_t;

  typedef struct packed {
    logic shift_en;
    logic acc_en;
    logic acc_clear;
    logic sampler_sync;
    logic sampler_blank;
    logic input_mode;
    logic test;
    logic dbl;
    logic chip_reset;
  } ic_ctrl_t;
endpackage : corr_pkg

// file: test/correlator_control_readout_props.sv
`timescale 1ns/10ps
module correlator_control_readout_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire corr_pkg::bcp_req_t bcp_req,
  input wire logic bcp_ack,
  input wire logic [15:0] bcp_rdata,
  input wire corr_pkg::ic_ctrl_t ic_ctrl [2],
  input wire logic link_left_oe,
  input wire logic link_right_oe,
  input wire logic sync_oe,
  input wire logic corr_clk_tick,
  input wire logic [1:0] result_ready
);
  import corr_pkg::*;
  logic [15:0] r4, ra, rc;
  logic [2:0] quiet;
  logic settled;
  // shadow copies of the static settings, so outputs can be tied to them
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r4 <= '0;
      ra <= '0;
      rc <= '0;
    end else if (bcp_req.wr) begin
      if (bcp_req.addr == OFS_EVENT_RANGE_CONTROL) r4 <= bcp_req.wdata;
      if (bcp_req.addr == OFS_READOUT_CONTROL) ra <= bcp_req.wdata;
      if (bcp_req.addr == OFS_DATAPATH_CLOCK_SELECT) rc <= bcp_req.wdata;
    end
  end
  // settings only judged once writes have been quiet long enough to land
  always_ff @(posedge ref_clk) begin
    if (rst || bcp_req.wr) quiet <= '0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  assign settled = quiet >= 3'h5;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_ack_follows_req: assert property ((bcp_req.rd || bcp_req.wr) |=> bcp_ack)
    else $error("request without acknowledge");
  chk_ack_has_cause: assert property (bcp_ack |-> $past(bcp_req.rd) || $past(bcp_req.wr))
    else $error("acknowledge without request");
  chk_rdata_holds: assert property (!bcp_req.rd |=> $stable(bcp_rdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (bcp_req.rd && !(bcp_req.addr inside
    {[15'h0000:15'h0004], [15'h0008:15'h000a], 15'h000c}) |=> bcp_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_idle_links: assert property (settled && r4[0] == r4[1] |->
    !link_left_oe && !link_right_oe)
    else $error("link driven in none or last position");
  chk_first_export: assert property (settled && r4[1:0] == 2'h1 |->
    link_left_oe && link_right_oe)
    else $error("first position not exporting");
  chk_mid_export: assert property (settled && r4[1:0] == 2'h2 |->
    link_right_oe == r4[3] && link_left_oe == !r4[3])
    else $error("intermediate export side wrong");
  chk_sync_master: assert property (settled |-> sync_oe == r4[2])
    else $error("sync drive differs from master bit");
  chk_full_rate: assert property (settled && rc[10:8] == 3'h0 |-> corr_clk_tick)
    else $error("divider zero without full rate");
  chk_ready_gate: assert property (|result_ready |-> ra[5])
    else $error("result taken while readout disabled");
  chk_chip_pick: assert property ((result_ready & {!ra[0], ra[0]}) == 2'b00)
    else $error("result taken from unselected chip");
  chk_clear_pulse: assert property (ic_ctrl[0].acc_clear |=> !ic_ctrl[0].acc_clear)
    else $error("accumulator clear longer than one cycle");
endmodule : correlator_control_readout_props

bind correlator_control_readout correlator_control_readout_props correlator_control_readout_props_i (
  .ref_clk(ref_clk), .rst(rst), .bcp_req(bcp_req), .bcp_ack(bcp_ack), .bcp_rdata(bcp_rdata),
  .ic_ctrl(ic_ctrl), .link_left_oe(link_left_oe), .link_right_oe(link_right_oe),
  .sync_oe(sync_oe), .corr_clk_tick(corr_clk_tick), .result_ready(result_ready)
);

// file: test/result_source_model.sv
`timescale 1ns/10ps
module result_source_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [1:0] start,
  input wire logic [1:0] result_ready,
  output logic [1:0] result_valid,
  output logic [31:0] result_data [2]
);
  logic pace;
  always_ff @(posedge ref_clk) begin
    pace <= rst ? 1'b0 : !pace;
  end
  for (genvar i = 0; i < 2; i++) begin : g_ic
    logic [10:0] idx;
    logic v;
    // lags in order then the total count, each offered once
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        idx <= 11'h401;
        v <= 1'b0;
      end else if (start[i]) begin
        idx <= 11'h000;
        v <= 1'b0;
      end else if (v && result_ready[i]) begin
        idx <= idx + 11'h001;
        v <= idx < 11'h400 && !slow;
      end else if (!v && idx < 11'h401 && (!slow || pace)) begin
        v <= 1'b1;
      end
    end
    // a restart withdraws the old offer at once, so no stale word follows a flush
    assign result_valid[i] = v && !start[i];
    // data follows the index, so a taken word never lingers
    assign result_data[i] = {4'(i), 1'b0, idx, 5'h1f, ~idx};
  end
endmodule : result_source_model

// file: test/correlator_control_readout_bench.sv
`timescale 1ns/10ps
module correlator_control_readout_bench;
  import corr_pkg::*;
  logic ref_clk, rst, bcp_ack, event_bus_strobe, slow, sync_in, sync_out, sync_oe;
  logic link_left_oe, link_right_oe, corr_clk_tick;
  bcp_req_t bcp_req;
  logic [15:0] bcp_rdata, event_lines, seed, q, lo;
  ic_ctrl_t ic_ctrl [2];
  ic_ctrl_t c;
  chain_link_t sampler_sample [2];
  chain_link_t ic_sample [2];
  chain_link_t aux_sample, link_left_in, link_right_in, link_left_out, link_right_out;
  logic [1:0] result_valid, result_ready;
  logic [31:0] result_data [2];
  logic [14:0] regs [7];
  logic [15:0] pat [7];
  logic [3:0] want [7];
  int bad_count, check_count, clr, c0;

  correlator_control_readout correlator_control_readout_i (
    .ref_clk(ref_clk), .rst(rst), .bcp_req(bcp_req), .bcp_ack(bcp_ack),
    .bcp_rdata(bcp_rdata), .event_lines(event_lines), .event_bus_strobe(event_bus_strobe),
    .ic_ctrl(ic_ctrl), .sampler_sample(sampler_sample), .aux_sample(aux_sample),
    .ic_sample(ic_sample), .link_left_in(link_left_in), .link_right_in(link_right_in),
    .link_left_out(link_left_out), .link_left_oe(link_left_oe),
    .link_right_out(link_right_out), .link_right_oe(link_right_oe), .sync_in(sync_in),
    .sync_out(sync_out), .sync_oe(sync_oe), .corr_clk_tick(corr_clk_tick),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data)
  );
  result_source_model result_source_model_i (
    .ref_clk(ref_clk), .rst(rst), .slow(slow),
    .start({ic_ctrl[1].acc_clear, ic_ctrl[0].acc_clear}),
    .result_ready(result_ready), .result_valid(result_valid), .result_data(result_data)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] word(input int ic, input logic [10:0] k);
    return {4'(ic), 1'b0, k, 5'h1f, ~k};
  endfunction : word
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic bus(input logic w, input logic [14:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    bcp_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk);
    #1;
    bcp_req = '0;
    check(bcp_ack, 1'b1);
    q = bcp_rdata;
  endtask : bus
  // lines settle before the strobe and stay well past its capture
  task automatic ev(input logic [15:0] lines);
    tick(1);
    event_lines = lines;
    tick(1);
    event_bus_strobe = 1'b1;
    tick(6);
    event_bus_strobe = 1'b0;
    tick(2);
  endtask : ev
  task automatic close_period();
    ev(16'h0018);
    ev(16'h0010);
    tick(12);
  endtask : close_period
  task automatic pair(input int ic, input logic [10:0] k);
    bus(1'b0, OFS_RESULT_LOW_HALF, 16'h0000);
    lo = q;
    bus(1'b0, OFS_RESULT_HIGH_HALF, 16'h0000);
    check({q, lo}, word(ic, k));
  endtask : pair
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  always @(posedge ref_clk) begin
    if (ic_ctrl[0].acc_clear === 1'b1) clr++;
  end
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (12000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    bcp_req = '0;
    event_lines = '0;
    event_bus_strobe = 1'b0;
    slow = 1'b0;
    sync_in = 1'b0;
    seed = 16'h004a;
    sampler_sample[0] = 4'h5;
    sampler_sample[1] = 4'ha;
    aux_sample = 4'h3;
    link_left_in = 4'h9;
    link_right_in = 4'h6;
    regs = '{OFS_EVENT_ROUTING_IC0, OFS_EVENT_ROUTING_IC1, OFS_CHIP_ENABLE_IC0,
      OFS_CHIP_ENABLE_IC1, OFS_EVENT_RANGE_CONTROL, OFS_READOUT_CONTROL,
      OFS_DATAPATH_CLOCK_SELECT};
    pat = '{16'h0018, 16'h001c, 16'h0018, 16'h0008, 16'h0060, 16'h0018, 16'h1800};
    want = '{4'hc, 4'h8, 4'hc, 4'h4, 4'h3, 4'h0, 4'hc};
    tick(20);
    rst = 1'b0;
    foreach (regs[i]) begin
      bus(1'b0, regs[i], 16'h0000);
      check(q, REG_RESET);
      seed = lfsr(seed);
      bus(1'b1, regs[i], seed);
      bus(1'b0, regs[i], 16'h0000);
      check(q, seed);
    end
    bus(1'b1, 15'h0005, 16'hffff);
    bus(1'b0, 15'h0005, 16'h0000);
    check(q, 16'h0000);
    bus(1'b1, OFS_DATAPATH_CLOCK_SELECT, 16'h0030);
    for (int p = 0; p < 4; p++) begin
      seed = lfsr(seed);
      sampler_sample[0] = seed[3:0];
      sampler_sample[1] = seed[7:4];
      bus(1'b1, OFS_EVENT_RANGE_CONTROL, {13'h0000, p[0], p[1:0]});
      tick(8);
      check({link_left_oe, link_right_oe}, (p == 1) ? 2'b11 : {p == 2, 1'b0});
      check({sync_oe, sync_out & !p[0]}, {p[0], 1'b0});
      check(corr_clk_tick, 1'b1);
      check(ic_sample[0], p[1] ? link_right_in : sampler_sample[0]);
      if (p == 1) begin
        check({link_left_out, link_right_out}, {sampler_sample[0], sampler_sample[1]});
      end else if (p == 2) begin
        check({link_left_out, link_right_out}, {link_right_in, 4'h0});
      end else begin
        check({link_left_out, link_right_out}, 8'h00);
      end
    end
    bus(1'b1, OFS_EVENT_RANGE_CONTROL, 16'h0000);
    for (int v = 10; v >= 0; v -= 10) begin
      bus(1'b1, OFS_CHIP_ENABLE_IC0, 16'(v));
      tick(3);
      c = ic_ctrl[0];
      check({c.input_mode, c.test, c.dbl, c.chip_reset}, {v[0], v[1], v[2], v[3]});
    end
    bus(1'b1, OFS_EVENT_ROUTING_IC0, 16'h272e);
    bus(1'b1, OFS_EVENT_ROUTING_IC1, 16'h272e);
    foreach (pat[i]) begin
      if (i == 5) bus(1'b1, OFS_EVENT_RANGE_CONTROL, 16'h0100);
      ev(pat[i]);
      c = ic_ctrl[i % 2];
      check({c.shift_en, c.acc_en, c.sampler_sync, c.sampler_blank}, want[i]);
    end
    c0 = clr;
    ev(16'h0000);
    check(32'(clr - c0), 32'h1);
    bus(1'b1, OFS_EVENT_RANGE_CONTROL, 16'h0000);
    bus(1'b1, OFS_READOUT_CONTROL, 16'h0000);
    close_period();
    bus(1'b0, OFS_RESULT_LOW_HALF, 16'h0000);
    check(q, 16'h0000);
    bus(1'b1, OFS_READOUT_CONTROL, 16'h0020);
    close_period();
    bus(1'b0, OFS_RESULT_LOW_HALF, 16'h0000);
    lo = q;
    bus(1'b0, OFS_RESULT_LOW_HALF, 16'h0000);
    check(q, lo);
    bus(1'b0, OFS_RESULT_HIGH_HALF, 16'h0000);
    check({q, lo}, word(0, 11'h000));
    // the whole set is drained before the next period closes
    for (int k = 1; k < 1025; k++) begin
      seed = lfsr(seed);
      slow = seed[0];
      pair(0, 11'(k));
    end
    bus(1'b0, OFS_RESULT_LOW_HALF, 16'h0000);
    check(q, 16'h0000);
    bus(1'b1, OFS_READOUT_CONTROL, 16'h0021);
    close_period();
    for (int k = 0; k < 16; k++) pair(1, 11'(k));
    stop_test();
  end
endmodule : correlator_control_readout_bench
